//--- verilog/self_test_pkg.sv
package self_test_pkg;
   localparam int LOG_DEPTH = 20;
   localparam int IDX_W = 5;
   localparam logic [2:0] SEL_SHORT = 3'h1;
   localparam logic [2:0] SEL_EXTENDED = 3'h2;
   localparam logic [2:0] SEL_ABORT = 3'h4;
   localparam logic [3:0] RES_PASS = 4'h0;
   localparam logic [3:0] RES_HOST_ABORT = 4'h1;
   localparam logic [3:0] RES_RESET_ABORT = 4'h2;
   localparam logic [3:0] RES_FAILED = 4'h7;
   localparam logic [3:0] RES_RUNNING = 4'hF;
   localparam logic [IDX_W-1:0] COUNT_RESET = 5'h00;

   typedef struct packed {
      logic [2:0] test_sel;
      logic [3:0] result;
      logic [63:0] fail_lba;
      logic [3:0] sense_key;
      logic [7:0] asc;
      logic [7:0] ascq;
      logic [7:0] fru;
   } log_entry_t;

   typedef struct packed {
      logic [63:0] lba;
      logic [3:0] sense_key;
      logic [7:0] asc;
      logic [7:0] ascq;
      logic [7:0] fru;
   } fail_info_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RUN,
      ST_SAVE
   } test_state_t;
endpackage : self_test_pkg

//--- verilog/self_test_results_log.sv
// How it works
// - A test start puts a new entry at index 0 and shifts older entries one place down.
// - At most 20 entries are held and the oldest falls off when a 21st would arrive.
// - The new entry's test-selection code is the code from the start command.
// - The new entry's result code starts as Fh meaning not finished.
// - Right after the new entry is made the whole log is committed to non-volatile storage.
// - On test end or abort the current entry's result is overwritten and storage updated.
// - A log read returns any of the up to 20 most recent entries.
// - The result code is 4 bits, zero for pass and nonzero naming the failure.
// - A failing test records the failing block address plus sense key, ASC, ASCQ and FRU.
// - A bus reset or bus device reset during a test ends that test.
// - The host abort code stops a running test and records result 01.
// - A stop by bus reset or bus device reset records result 02 for an interruption by reset.
// - The test-selection code is command byte 1 bits 7:5, 001b short and 010b extended.
// - Only unrecovered seek, track-follow, read or write errors count as failures.
module self_test_results_log (
   input wire logic clk_in,
   input wire logic nrst_in,
   // Host command side
   input wire logic cmd_valid_in,
   input wire logic [7:0] cmd_byte1_in,
   output logic cmd_refused_out,
   output logic test_start_out,
   output logic [2:0] test_sel_out,
   output logic test_running_out,
   // Test engine side
   input wire logic test_done_in,
   input wire logic unrecovered_err_in,
   input wire logic recovered_err_in,
   input wire self_test_pkg::fail_info_t fail_info_in,
   // Reset sources and engine stop
   input wire logic bus_reset_in,
   input wire logic device_reset_msg_in,
   output logic test_abort_out,
   // Non-volatile storage side
   output logic nv_save_out,
   input wire logic nv_done_in,
   output logic nv_busy_out,
   // Log read side
   input wire logic [4:0] rd_index_in,
   output self_test_pkg::log_entry_t rd_entry_out,
   output logic rd_valid_out,
   output logic [4:0] entry_count_out
);
   import self_test_pkg::*;

   // ************************************************
   // Log state
   // ************************************************
   // Whole log lives in one register struct; entry 0 is always the newest
   typedef struct packed {
      test_state_t state;
      log_entry_t [LOG_DEPTH-1:0] entries;
      logic [IDX_W-1:0] count;
      // Failure captured during the running test
      logic failed;
      fail_info_t info;
      logic [2:0] sel;
      logic nv_req;
      logic abort;
      logic refused;
      logic start;
      // Registered read port
      log_entry_t rd_entry;
      logic rd_valid;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   logic [2:0] cmd_sel;
   logic start_req;
   logic abort_req;
   logic reset_abort;
   fail_info_t fail_pick;

   // ************************************************
   // Decode helpers
   // ************************************************
   function automatic logic is_start_code(input logic [2:0] sel);
      return (sel == SEL_SHORT) || (sel == SEL_EXTENDED);
   endfunction : is_start_code

   function automatic logic is_abort_code(input logic [2:0] sel);
      return sel == SEL_ABORT;
   endfunction : is_abort_code

   // ************************************************
   // Command decode
   // ************************************************
   assign cmd_sel = cmd_byte1_in[7:5];
   assign start_req = cmd_valid_in && is_start_code(cmd_sel);
   assign abort_req = cmd_valid_in && is_abort_code(cmd_sel);
   // Both reset kinds end a test the same way and are logged alike
   assign reset_abort = bus_reset_in || device_reset_msg_in;
   // Earliest failure wins; one arriving with the done pulse is used if none came before
   assign fail_pick = s_r.failed ? s_r.info : fail_info_in;

   // ************************************************
   // Next-state logic
   // ************************************************
   always_comb begin
      s_nxt = s_r;
      // Pulses last one cycle unless set again below
      s_nxt.nv_req = 1'b0;
      s_nxt.abort = 1'b0;
      s_nxt.refused = 1'b0;
      s_nxt.start = 1'b0;
      case (s_r.state)
         ST_IDLE: begin
            // Abort and reserved codes are dropped silently when idle
            if (start_req) begin
               for (int i = LOG_DEPTH - 1; i > 0; i--) begin
                  s_nxt.entries[i] = s_r.entries[i-1];
               end
               s_nxt.entries[0] = '0;
               s_nxt.entries[0].test_sel = cmd_sel;
               s_nxt.entries[0].result = RES_RUNNING;
               // Count saturates at the depth; the shift above already dropped the oldest
               if (s_r.count != IDX_W'(LOG_DEPTH)) begin
                  s_nxt.count = s_r.count + 5'h01;
               end

               // Fresh test starts with no failure captured
               s_nxt.sel = cmd_sel;
               s_nxt.failed = 1'b0;
               s_nxt.info = '0;
               s_nxt.start = 1'b1;
               s_nxt.nv_req = 1'b1;
               s_nxt.state = ST_RUN;
            end
         end

         ST_RUN: begin
            // First unrecovered error is kept; recovered ones are ignored
            if (unrecovered_err_in && !s_r.failed) begin
               s_nxt.failed = 1'b1;
               s_nxt.info = fail_info_in;
            end

            // Log left untouched by a refused start
            if (start_req) begin
               s_nxt.refused = 1'b1;
            end
            // Reset outranks a host abort, which outranks a normal end
            if (reset_abort) begin
               s_nxt.entries[0].result = RES_RESET_ABORT;
               s_nxt.abort = 1'b1;
               s_nxt.nv_req = 1'b1;
               s_nxt.state = ST_SAVE;
            end else if (abort_req) begin
               // Host abort only counts while a test runs
               s_nxt.entries[0].result = RES_HOST_ABORT;
               s_nxt.abort = 1'b1;
               s_nxt.nv_req = 1'b1;
               s_nxt.state = ST_SAVE;
            end else if (test_done_in) begin
               if (s_r.failed || unrecovered_err_in) begin
                  s_nxt.entries[0].result = RES_FAILED;
                  s_nxt.entries[0].fail_lba = fail_pick.lba;
                  s_nxt.entries[0].sense_key = fail_pick.sense_key;
                  s_nxt.entries[0].asc = fail_pick.asc;
                  s_nxt.entries[0].ascq = fail_pick.ascq;
                  s_nxt.entries[0].fru = fail_pick.fru;
               end else begin
                  s_nxt.entries[0].result = RES_PASS;
               end
               s_nxt.nv_req = 1'b1;
               s_nxt.state = ST_SAVE;
            end
         end

         ST_SAVE: begin
            // Wait for the final commit so a new start cannot race the save
            if (start_req) begin
               s_nxt.refused = 1'b1;
            end
            // Limitation: storage must not answer the start commit after the final request
            if (nv_done_in && !s_r.nv_req) begin
               s_nxt.state = ST_IDLE;
            end
         end

         default: begin
            s_nxt.state = ST_IDLE;
         end
      endcase

      // Read port: registered copy of the chosen entry, blank past the end
      s_nxt.rd_valid = rd_index_in < s_r.count;
      s_nxt.rd_entry = (rd_index_in < s_r.count) ? s_r.entries[rd_index_in] : '0;

      // Synchronous reset empties the log and clears every pulse
      if (!nrst_in) begin
         s_nxt = '0;
         s_nxt.state = ST_IDLE;
         s_nxt.count = COUNT_RESET;
      end
   end

   // ************************************************
   // Registers
   // ************************************************
   always_ff @(posedge clk_in) begin
      s_r <= s_nxt;
   end

   // ************************************************
   // Outputs
   // ************************************************
   assign cmd_refused_out = s_r.refused;
   assign test_start_out = s_r.start;
   assign test_sel_out = s_r.sel;
   assign test_running_out = (s_r.state == ST_RUN);
   assign test_abort_out = s_r.abort;
   assign nv_save_out = s_r.nv_req;
   assign nv_busy_out = (s_r.state == ST_SAVE);
   assign rd_entry_out = s_r.rd_entry;
   assign rd_valid_out = s_r.rd_valid;
   assign entry_count_out = s_r.count;
endmodule : self_test_results_log

//--- verification/self_test_results_log_properties.sv
module self_test_log_checker
   import self_test_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic cmd_valid_in,
   input wire logic [7:0] cmd_byte1_in,
   input wire logic cmd_refused_out,
   input wire logic test_start_out,
   input wire logic [2:0] test_sel_out,
   input wire logic test_running_out,
   input wire logic test_done_in,
   input wire logic bus_reset_in,
   input wire logic device_reset_msg_in,
   input wire logic test_abort_out,
   input wire logic nv_save_out,
   input wire logic nv_busy_out,
   input wire logic [4:0] entry_count_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   sequence s_start;
      cmd_valid_in && (cmd_byte1_in[7:5] == SEL_SHORT || cmd_byte1_in[7:5] == SEL_EXTENDED);
   endsequence
   sequence s_busy;
      test_running_out || nv_busy_out;
   endsequence
   chk_start_taken: assert property (s_start ##0 !(test_running_out || nv_busy_out)
      |=> test_start_out && nv_save_out)
      else $error("start lost");
   chk_sel_copy: assert property (test_start_out |-> test_sel_out == $past(cmd_byte1_in[7:5]))
      else $error("bad selection");
   chk_refuse_busy: assert property (s_start ##0 s_busy |=> cmd_refused_out && !test_start_out)
      else $error("start not refused");
   chk_count_cap: assert property (entry_count_out <= 5'h14)
      else $error("count too big");
   chk_count_step: assert property (test_start_out |-> entry_count_out ==
      ($past(entry_count_out) == 5'h14 ? 5'h14 : $past(entry_count_out) + 5'h01))
      else $error("bad count step");
   chk_reset_abort: assert property (test_running_out && (bus_reset_in || device_reset_msg_in)
      |=> test_abort_out && nv_save_out && nv_busy_out)
      else $error("reset abort lost");
   chk_host_abort: assert property (test_running_out && cmd_valid_in && cmd_byte1_in[7:5] == SEL_ABORT
      |=> test_abort_out ##1 nv_busy_out)
      else $error("host abort lost");
   chk_done_save: assert property (test_running_out && test_done_in && !cmd_valid_in && !bus_reset_in
      && !device_reset_msg_in |=> nv_save_out && !test_abort_out && !test_running_out)
      else $error("end not saved");
endmodule : self_test_log_checker
bind self_test_results_log self_test_log_checker i_chk (.clk_in, .nrst_in, .cmd_valid_in, .cmd_byte1_in,
   .cmd_refused_out, .test_start_out, .test_sel_out, .test_running_out, .test_done_in, .bus_reset_in,
   .device_reset_msg_in, .test_abort_out, .nv_save_out, .nv_busy_out, .entry_count_out);

//--- verification/media_self_test_partner.sv
module media_self_test_partner (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic nv_save_in,
   input wire logic test_start_in,
   input wire logic test_abort_in,
   input wire logic [7:0] run_len_in,
   output logic nv_done_out,
   output logic test_done_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] nv_r;
   logic [7:0] run_r;
   // Upper nibble sets the storage delay, so one knob gives prompt and slow answers
   always_ff @(posedge clk_in) begin
      nv_r <= !nrst_in ? 8'h00 : nv_save_in ? {4'h0, run_len_in[7:4]} + 8'h01 : nv_r - {7'h00, nv_r != 8'h00};
      run_r <= !nrst_in || test_abort_in ? 8'h00 : test_start_in ? run_len_in : run_r - {7'h00, run_r != 8'h00};
      nv_done_out <= nrst_in && nv_r == 8'h01;
      test_done_out <= nrst_in && run_r == 8'h01 && !test_abort_in;
   end
endmodule : media_self_test_partner

//--- verification/self_test_results_log_bench.sv
module self_test_results_log_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import self_test_pkg::*;
   logic clk_in = 1'b0, nrst_in = 1'b0, cmd_valid_in = 1'b0, bus_reset_in = 1'b0, device_reset_msg_in = 1'b0;
   logic unrecovered_err_in = 1'b0, recovered_err_in = 1'b0;
   logic [7:0] cmd_byte1_in = 8'h00, run_len = 8'h06;
   logic [4:0] rd_index_in = 5'h00;
   fail_info_t fail_info_in = '0;
   logic cmd_refused_out, test_start_out, test_running_out, test_done_in, test_abort_out;
   logic nv_save_out, nv_done_in, nv_busy_out, rd_valid_out;
   logic [2:0] test_sel_out;
   logic [4:0] entry_count_out;
   log_entry_t rd_entry_out;
   int bad_count = 0, checks = 0, cycles = 0;
   always #10 clk_in = ~clk_in;
   self_test_results_log i_self_test_results_log (.clk_in, .nrst_in, .cmd_valid_in, .cmd_byte1_in,
      .cmd_refused_out, .test_start_out, .test_sel_out, .test_running_out, .test_done_in, .unrecovered_err_in,
      .recovered_err_in, .fail_info_in, .bus_reset_in, .device_reset_msg_in, .test_abort_out, .nv_save_out,
      .nv_done_in, .nv_busy_out, .rd_index_in, .rd_entry_out, .rd_valid_out, .entry_count_out);
   media_self_test_partner i_media_self_test_partner (.clk_in, .nrst_in, .nv_save_in(nv_save_out),
      .test_start_in(test_start_out), .test_abort_in(test_abort_out), .run_len_in(run_len),
      .nv_done_out(nv_done_in), .test_done_out(test_done_in));
   task automatic close_out;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         close_out();
      end
   end
   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("wrong value %0t %s", $time, m);
      end
   endtask : chk
   task automatic cmd(input logic [2:0] sel);
      cmd_byte1_in = {sel, 5'h00};
      cmd_valid_in = 1'b1;
      @(negedge clk_in);
      cmd_valid_in = 1'b0;
   endtask : cmd
   task automatic end_top(input logic [3:0] res);
      for (int i = 0; i < 300 && (test_running_out !== 1'b0 || nv_busy_out !== 1'b0); i++) @(negedge clk_in);
      repeat (2) @(negedge clk_in);
      chk(rd_entry_out.result === res, "result code");
   endtask : end_top
   task automatic t_pass;
      cmd(SEL_SHORT);
      chk(test_start_out === 1'b1 && nv_save_out === 1'b1 && entry_count_out === 5'h01, "start");
      @(negedge clk_in);
      chk(rd_entry_out.test_sel === SEL_SHORT && rd_entry_out.result === RES_RUNNING, "new entry");
      recovered_err_in = 1'b1;
      end_top(RES_PASS);
      recovered_err_in = 1'b0;
   endtask : t_pass
   task automatic t_fail;
      cmd(SEL_EXTENDED);
      fail_info_in = '{64'h0000_0001_2345_6789, 4'h3, 8'h11, 8'h04, 8'h2A};
      unrecovered_err_in = 1'b1;
      @(negedge clk_in);
      unrecovered_err_in = 1'b0;
      end_top(RES_FAILED);
      chk(rd_entry_out[91:0] === fail_info_in, "fail info");
   endtask : t_fail
   task automatic t_refuse;
      cmd(SEL_SHORT);
      @(negedge clk_in);
      cmd(SEL_EXTENDED);
      chk(cmd_refused_out === 1'b1 && test_start_out === 1'b0, "not refused");
      end_top(RES_PASS);
      chk(rd_entry_out.test_sel === SEL_SHORT, "log changed");
   endtask : t_refuse
   task automatic t_abort(input int kind);
      run_len = 8'h40;
      cmd(SEL_SHORT);
      @(negedge clk_in);
      if (kind == 0) cmd(SEL_ABORT);
      else begin
         bus_reset_in = kind == 1;
         device_reset_msg_in = kind == 2;
         @(negedge clk_in);
         bus_reset_in = 1'b0;
         device_reset_msg_in = 1'b0;
      end
      chk(test_abort_out === 1'b1, "no abort");
      end_top(kind == 0 ? RES_HOST_ABORT : RES_RESET_ABORT);
   endtask : t_abort
   task automatic t_fill;
      repeat (22) begin
         cmd(SEL_EXTENDED);
         end_top(RES_PASS);
      end
      chk(entry_count_out === 5'h14, "count cap");
      rd_index_in = 5'h13;
      repeat (2) @(negedge clk_in);
      chk(rd_valid_out === 1'b1 && rd_entry_out.test_sel === SEL_EXTENDED, "oldest kept");
      rd_index_in = 5'h14;
      repeat (2) @(negedge clk_in);
      chk(rd_valid_out === 1'b0, "past end");
   endtask : t_fill
   task automatic t_reset;
      rd_index_in = 5'h00;
      cmd(SEL_SHORT);
      repeat (2) @(negedge clk_in);
      nrst_in = 1'b0;
      repeat (2) @(negedge clk_in);
      nrst_in = 1'b1;
      chk(entry_count_out === 5'h00 && test_running_out === 1'b0 && nv_busy_out === 1'b0, "reset state");
      chk(rd_valid_out === 1'b0 && test_abort_out === 1'b0 && nv_save_out === 1'b0, "reset outputs");
      cmd(SEL_EXTENDED);
      chk(test_start_out === 1'b1 && entry_count_out === 5'h01, "start after reset");
      end_top(RES_PASS);
   endtask : t_reset
   initial begin
      repeat (16) @(negedge clk_in);
      nrst_in = 1'b1;
      t_pass();
      t_fail();
      t_refuse();
      for (int k = 0; k < 3; k++) t_abort(k);
      run_len = 8'h06;
      t_fill();
      t_reset();
      close_out();
   end
endmodule : self_test_results_log_bench
